// ### src/kpc_pkg.sv
// kpc_pkg: constants, types and register map of the port and keypad block
// assumes a 32-bit ahb-lite slave with word registers at byte address 4*index
package kpc_pkg;

  localparam int KPC_PORTS = 5;
  localparam int KPC_W = 8;
  localparam int KPC_KEY_PORT = 1;
  localparam int KPC_ALIAS_BIT = 10;

  typedef logic [7:0] kpc_byte_t;

  // register indices, byte address is four times the index
  localparam kpc_byte_t KPC_IDX_DATA [KPC_PORTS] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0};
  localparam kpc_byte_t KPC_IDX_MODE1 [KPC_PORTS] = '{8'hd4, 8'he6, 8'hd6, 8'hde, 8'hbe};
  localparam kpc_byte_t KPC_IDX_MODE2 [KPC_PORTS] = '{8'hd5, 8'he7, 8'hd7, 8'hcf, 8'hbf};
  localparam kpc_byte_t KPC_IDX_KEY_POL = 8'h9c;
  localparam kpc_byte_t KPC_IDX_KEY_EN = 8'h9d;
  localparam kpc_byte_t KPC_IDX_KEY_FLAGS = 8'h9e;
  localparam kpc_byte_t KPC_IDX_KEY_TYPE = 8'h9f;

  // reset values
  localparam kpc_byte_t KPC_LATCH_RST = 8'hff;
  localparam kpc_byte_t KPC_KEY_RST = 8'h00;
  localparam kpc_byte_t KPC_MODE1_FUSE_ON [KPC_PORTS] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hc7};
  localparam kpc_byte_t KPC_MODE1_FUSE_OFF [KPC_PORTS] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03};
  localparam kpc_byte_t KPC_MODE2_RST [KPC_PORTS] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03};

  // input buffers kept alive in power-down besides enabled key pins
  localparam kpc_byte_t KPC_PD_KEEP [KPC_PORTS] = '{8'h00, 8'h00, 8'h00, 8'h0c, 8'hc0};

  // pin mode, {first bit, second bit}
  typedef enum logic [1:0] {
    KPC_MODE_QUASI = 2'b00,
    KPC_MODE_PUSH = 2'b01,
    KPC_MODE_INPUT = 2'b10,
    KPC_MODE_ODRAIN = 2'b11
  } kpc_mode_e;

  // bus data-phase state
  typedef enum logic [0:0] {
    KPC_BUS_OPEN = 1'b0,
    KPC_BUS_RDWAIT = 1'b1
  } kpc_bus_e;

  // pad controls for one port
  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] oe_n;
    logic [7:0] weak_pu;
    logic [7:0] vweak_pu;
    logic [7:0] in_en;
  } kpc_pad_s;

endpackage

// ### src/kpc_port_ctrl.sv
// kpc_port_ctrl: five 8-bit ports with mode control and eight keypad irq pins
// assumes an ahb-lite master on hclk, pad inputs synchronous to hclk,
// and a fuse strap that is steady from reset onward
//
// Summary of operation
// - eight port-one sources share one irq
// - key enable bit gates each pin's flag
// - type bit: 0 level, 1 edge
// - polarity: 0 low/falling, 1 high/rising
// - port-one pins sampled every clock
// - level needs two consecutive matching samples
// - edge when sample differs in chosen direction
// - detected enabled condition sets sticky flag
// - reads keep flags; writing zeros clears
// - writing one sets a flag
// - enabled key irq wakes idle, power-down
// - enabled key input buffers stay on in power-down
// - power-down disables other inputs except few
// - two mode bits pick four pin modes
// - ports one-three reset per tristate fuse
// - port zero fixed reset modes; port four partly per fuse
// - first mode register resets of ports one-four follow fuse
// - quasi strong pull-up one clock on rise
// - push-pull drives high; open-drain low only
// - plain read pins, rmw read latch
`timescale 1ns/1ps

module kpc_port_ctrl
  import kpc_pkg::*;
#(
  parameter int KEY_PINS = KPC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tristate_fuse,
  input wire logic power_down,
  input wire logic [KPC_PORTS-1:0][7:0] pad_in,
  output kpc_pad_s [KPC_PORTS-1:0] pad_ctl,
  output logic key_irq,
  output logic wake_req
);

  initial begin
    if (KEY_PINS < 1 || KEY_PINS > KPC_W) begin
      $error("KEY_PINS must lie between 1 and 8");
    end
  end

  localparam logic [7:0] KEY_MASK = 8'((9'h001 << KEY_PINS) - 9'h001);

  // bus state
  kpc_bus_e bus_state;
  logic dp_valid;
  logic dp_write;
  logic dp_high_ok;
  logic [10:0] dp_addr;
  logic [7:0] dp_idx;
  logic dp_alias;
  logic acc_take;
  logic wr_strobe;
  logic [7:0] rd_mux;

  // registers
  logic [KPC_PORTS-1:0][7:0] port_latch;
  logic [KPC_PORTS-1:0][7:0] latch_prev;
  logic [KPC_PORTS-1:0][7:0] mode_first;
  logic [KPC_PORTS-1:0][7:0] mode_second;
  logic [7:0] key_polarity_select;
  logic [7:0] key_irq_enable;
  logic [7:0] key_irq_flags;
  logic [7:0] key_detect_type;
  logic fuse_done;

  // key detection
  logic [7:0] key_s1;
  logic [7:0] key_s2;
  logic [7:0] lvl_hit;
  logic [7:0] edge_hit;
  logic [7:0] key_set;
  logic [7:0] next_key_irq_flags;

  // write strobes
  logic [KPC_PORTS-1:0] wr_latch;
  logic [KPC_PORTS-1:0] wr_mode1;
  logic [KPC_PORTS-1:0] wr_mode2;
  logic wr_key_pol;
  logic wr_key_en;
  logic wr_key_flags;
  logic wr_key_type;

  // ---------------------------------------------------------------
  // ahb-lite address phase capture
  assign acc_take = hready & hsel & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_high_ok <= 1'b0;
      dp_addr <= 11'h000;
    end else if (hready) begin
      dp_valid <= acc_take;
      dp_write <= hwrite;
      dp_high_ok <= (haddr[31:11] == 21'h000000);
      dp_addr <= haddr[10:0];
    end
  end

  // reads take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= KPC_BUS_OPEN;
    end else begin
      case (bus_state)
        KPC_BUS_OPEN: begin
          if (acc_take && !hwrite) begin
            bus_state <= KPC_BUS_RDWAIT;
          end
        end
        KPC_BUS_RDWAIT: begin
          bus_state <= KPC_BUS_OPEN;
        end
        default: begin
          bus_state <= KPC_BUS_OPEN;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_state == KPC_BUS_RDWAIT) begin
      hrdata <= {24'h000000, rd_mux};
    end
  end

  assign hreadyout = (bus_state == KPC_BUS_OPEN);
  assign hresp = 1'b0;
  assign dp_idx = dp_addr[9:2];
  assign dp_alias = dp_addr[KPC_ALIAS_BIT];
  assign wr_strobe = dp_valid & dp_write & dp_high_ok;

  // write decode
  always_comb begin
    wr_latch = '0;
    wr_mode1 = '0;
    wr_mode2 = '0;
    wr_key_pol = 1'b0;
    wr_key_en = 1'b0;
    wr_key_flags = 1'b0;
    wr_key_type = 1'b0;
    for (int p = 0; p < KPC_PORTS; p++) begin
      if (dp_idx == KPC_IDX_DATA[p]) begin
        wr_latch[p] = wr_strobe;
      end else if (dp_idx == KPC_IDX_MODE1[p] && !dp_alias) begin
        wr_mode1[p] = wr_strobe;
      end else if (dp_idx == KPC_IDX_MODE2[p] && !dp_alias) begin
        wr_mode2[p] = wr_strobe;
      end
    end
    if (dp_alias) begin
      wr_key_pol = 1'b0;
    end else if (dp_idx == KPC_IDX_KEY_POL) begin
      wr_key_pol = wr_strobe;
    end else if (dp_idx == KPC_IDX_KEY_EN) begin
      wr_key_en = wr_strobe;
    end else if (dp_idx == KPC_IDX_KEY_FLAGS) begin
      wr_key_flags = wr_strobe;
    end else if (dp_idx == KPC_IDX_KEY_TYPE) begin
      wr_key_type = wr_strobe;
    end
  end

  // read mux; unmapped reads give zero
  always_comb begin
    rd_mux = 8'h00;
    if (!dp_high_ok) begin
      rd_mux = 8'h00;
    end else if (!dp_alias && dp_idx == KPC_IDX_KEY_POL) begin
      rd_mux = key_polarity_select;
    end else if (!dp_alias && dp_idx == KPC_IDX_KEY_EN) begin
      rd_mux = key_irq_enable;
    end else if (!dp_alias && dp_idx == KPC_IDX_KEY_FLAGS) begin
      rd_mux = key_irq_flags;
    end else if (!dp_alias && dp_idx == KPC_IDX_KEY_TYPE) begin
      rd_mux = key_detect_type;
    end else begin
      for (int p = 0; p < KPC_PORTS; p++) begin
        if (dp_idx == KPC_IDX_DATA[p]) begin
          rd_mux = dp_alias ? port_latch[p] : pad_in[p];
        end else if (!dp_alias && dp_idx == KPC_IDX_MODE1[p]) begin
          rd_mux = mode_first[p];
        end else if (!dp_alias && dp_idx == KPC_IDX_MODE2[p]) begin
          rd_mux = mode_second[p];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fuse strap is caught on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fuse_done <= 1'b0;
    end else begin
      fuse_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // per-port registers and pad drive
  genvar gp, gb;
  generate
    for (gp = 0; gp < KPC_PORTS; gp++) begin : g_port
      logic [7:0] in_keep;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          port_latch[gp] <= KPC_LATCH_RST;
        end else if (wr_latch[gp]) begin
          port_latch[gp] <= hwdata[7:0];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          latch_prev[gp] <= KPC_LATCH_RST;
        end else begin
          latch_prev[gp] <= port_latch[gp];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mode_first[gp] <= KPC_MODE1_FUSE_OFF[gp];
        end else if (!fuse_done) begin
          mode_first[gp] <= tristate_fuse ? KPC_MODE1_FUSE_ON[gp]
                                          : KPC_MODE1_FUSE_OFF[gp];
        end else if (wr_mode1[gp]) begin
          mode_first[gp] <= hwdata[7:0];
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mode_second[gp] <= KPC_MODE2_RST[gp];
        end else if (wr_mode2[gp]) begin
          mode_second[gp] <= hwdata[7:0];
        end
      end

      // power-down input buffer gating
      if (gp == KPC_KEY_PORT) begin : g_keep_key
        assign in_keep = KPC_PD_KEEP[gp] | (key_irq_enable & KEY_MASK);
      end else begin : g_keep_fixed
        assign in_keep = KPC_PD_KEEP[gp];
      end
      assign pad_ctl[gp].in_en = power_down ? in_keep : 8'hff;

      for (gb = 0; gb < KPC_W; gb++) begin : g_bit
        kpc_mode_e mode;
        logic lat;
        logic rise;

        assign mode = kpc_mode_e'({mode_first[gp][gb], mode_second[gp][gb]});
        assign lat = port_latch[gp][gb];
        assign rise = lat & ~latch_prev[gp][gb];

        always_comb begin
          pad_ctl[gp].drv[gb] = 1'b0;
          pad_ctl[gp].oe_n[gb] = 1'b1;
          pad_ctl[gp].weak_pu[gb] = 1'b0;
          pad_ctl[gp].vweak_pu[gb] = 1'b0;
          case (mode)
            KPC_MODE_QUASI: begin
              pad_ctl[gp].drv[gb] = rise;
              pad_ctl[gp].oe_n[gb] = lat & ~rise;
              pad_ctl[gp].weak_pu[gb] = lat & pad_in[gp][gb];
              pad_ctl[gp].vweak_pu[gb] = lat;
            end
            KPC_MODE_PUSH: begin
              pad_ctl[gp].drv[gb] = lat;
              pad_ctl[gp].oe_n[gb] = 1'b0;
            end
            KPC_MODE_INPUT: begin
              pad_ctl[gp].oe_n[gb] = 1'b1;
            end
            KPC_MODE_ODRAIN: begin
              pad_ctl[gp].oe_n[gb] = lat;
            end
            default: begin
              pad_ctl[gp].oe_n[gb] = 1'b1;
            end
          endcase
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // keypad configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_polarity_select <= KPC_KEY_RST;
    end else if (wr_key_pol) begin
      key_polarity_select <= hwdata[7:0] & KEY_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_irq_enable <= KPC_KEY_RST;
    end else if (wr_key_en) begin
      key_irq_enable <= hwdata[7:0] & KEY_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_detect_type <= KPC_KEY_RST;
    end else if (wr_key_type) begin
      key_detect_type <= hwdata[7:0] & KEY_MASK;
    end
  end

  // port-one samples, one per clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_s1 <= 8'h00;
      key_s2 <= 8'h00;
    end else begin
      key_s1 <= pad_in[KPC_KEY_PORT];
      key_s2 <= key_s1;
    end
  end

  assign lvl_hit = ~(key_s1 ^ key_polarity_select) & ~(key_s2 ^ key_polarity_select);
  assign edge_hit = (key_s1 ^ key_s2) & ~(key_s1 ^ key_polarity_select);
  assign key_set = ((key_detect_type & edge_hit) | (~key_detect_type & lvl_hit))
                   & key_irq_enable & KEY_MASK;

  // flags: write value stands, hardware sets on top
  always_comb begin
    if (wr_key_flags) begin
      next_key_irq_flags = (hwdata[7:0] & KEY_MASK) | key_set;
    end else begin
      next_key_irq_flags = key_irq_flags | key_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_irq_flags <= KPC_KEY_RST;
    end else begin
      key_irq_flags <= next_key_irq_flags;
    end
  end

  assign key_irq = |key_irq_flags;
  assign wake_req = (|key_irq_flags) | (|key_set);

endmodule

// ### test/kpc_chk.sv
// kpc_chk: bus and keypad relations at the block's ports
// bound to kpc_port_ctrl, hready fed from hreadyout
`timescale 1ns/1ps
module kpc_chk
  import kpc_pkg::*;
#(
  parameter int KEY_PINS = KPC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic power_down,
  input wire kpc_pad_s [KPC_PORTS-1:0] pad_ctl,
  input wire logic key_irq,
  input wire logic wake_req
);
  logic wr_dp;
  wire logic take = hready && hsel && htrans[1];
  // flag write in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
    end else if (hready) begin
      wr_dp <= take && hwrite && haddr == {22'h0, KPC_IDX_KEY_FLAGS, 2'b00};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd; take && !hwrite; endsequence
  sequence s_wr; take && hwrite; endsequence
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_rd_wait; s_rd |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait; s_wr |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_hold; $changed(hrdata) && $past(hresetn) |-> !$past(hreadyout); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wake; key_irq |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("pending flag without wake");
  property p_set; wake_req && !key_irq |=> key_irq; endproperty
  a_set: assert property (p_set) else $error("detection lost");
  property p_rise; $rose(key_irq) && $past(hresetn) |-> $past(wake_req) || $past(wr_dp); endproperty
  a_rise: assert property (p_rise) else $error("flag set without cause");
  property p_fall; $fell(key_irq) && $past(hresetn) |-> $past(wr_dp); endproperty
  a_fall: assert property (p_fall) else $error("flag lost without write");
  property p_pd;
    power_down |-> pad_ctl[0].in_en == 8'h00 && pad_ctl[2].in_en == 8'h00 &&
      pad_ctl[3].in_en == 8'h0c && pad_ctl[4].in_en == 8'hc0;
  endproperty
  a_pd: assert property (p_pd) else $error("input left on in power-down");
endmodule

bind kpc_port_ctrl kpc_chk #(.KEY_PINS(KEY_PINS)) kpc_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .power_down(power_down),
  .pad_ctl(pad_ctl), .key_irq(key_irq), .wake_req(wake_req));

// ### test/kpc_pad_model.sv
// kpc_pad_model: far side of the pads, keypad and sources on port one
// pad shows the block's drive where enabled, else the external level
`timescale 1ns/1ps
module kpc_pad_model
  import kpc_pkg::*;
(
  input wire logic hclk,
  input wire kpc_pad_s [KPC_PORTS-1:0] pad_ctl,
  input wire logic [KPC_PORTS-1:0][7:0] ext,
  output logic [KPC_PORTS-1:0][7:0] pad_in
);
  initial pad_in = '1;
  always @(posedge hclk) begin
    for (int p = 0; p < KPC_PORTS; p++) begin
      pad_in[p] <= (pad_ctl[p].drv & ~pad_ctl[p].oe_n) | (ext[p] & pad_ctl[p].oe_n);
    end
  end
endmodule

// ### test/tb_port_pin_config_and_keypad_irq.sv
// tb_port_pin_config_and_keypad_irq: self-checking bench for kpc_port_ctrl
// drives the ahb-lite port, fuse strap, power-down and the pad model
`timescale 1ns/1ps
module tb_port_pin_config_and_keypad_irq;
  import kpc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic tristate_fuse = 1'b1, power_down = 1'b0, hreadyout, hresp, key_irq, wake_req;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [KPC_PORTS-1:0][7:0] pad_in, ext = '1;
  kpc_pad_s [KPC_PORTS-1:0] pad_ctl;
  int miscompares = 0, n_compared = 0, cycles = 0;
  localparam logic [31:0] FLG = {22'h0, KPC_IDX_KEY_FLAGS, 2'b00};
  always #20 hclk = ~hclk;
  kpc_port_ctrl #(.KEY_PINS(8)) kpc_port_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tristate_fuse(tristate_fuse), .power_down(power_down), .pad_in(pad_in),
    .pad_ctl(pad_ctl), .key_irq(key_irq), .wake_req(wake_req));
  kpc_pad_model kpc_pad_model_i (.hclk(hclk), .pad_ctl(pad_ctl), .ext(ext), .pad_in(pad_in));
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] ra(input kpc_byte_t i);
    return {22'h0, i, 2'b00};
  endfunction
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  task automatic t_reset(input logic fuse);
    hresetn <= 1'b0;
    tristate_fuse <= fuse;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int p = 0; p < KPC_PORTS; p++) begin
      rdc(ra(KPC_IDX_MODE1[p]), p == 0 ? 8'hff : p == 4 ? (fuse ? 8'hc7 : 8'h03) : {8{fuse}});
      rdc(ra(KPC_IDX_MODE2[p]), p == 0 ? 8'hff : p == 4 ? 8'h03 : 8'h00);
      rdc(ra(KPC_IDX_DATA[p]) + 32'h400, 8'hff);
    end
    for (int k = 0; k < 4; k++) begin
      rdc(ra(KPC_IDX_KEY_POL) + 32'(4 * k), 8'h00);
    end
    check(pad_ctl[1].vweak_pu, fuse ? 8'h00 : 8'hff);
    check(pad_ctl[4].vweak_pu, fuse ? 8'h38 : 8'hfc);
    wr(32'h3fc, 8'h5a);
    rdc(32'h3fc, 8'h00);
  endtask
  task automatic t_modes();
    wr(ra(KPC_IDX_MODE1[2]), 8'hf0);
    wr(ra(KPC_IDX_MODE2[2]), 8'hcc);
    wr(ra(KPC_IDX_DATA[2]), 8'haa);
    @(negedge hclk);
    check(pad_ctl[2].oe_n, 8'hb2);
    check(pad_ctl[2].drv & ~pad_ctl[2].oe_n, 8'h08);
    check(pad_ctl[2].weak_pu, 8'h02);
    wr(ra(KPC_IDX_DATA[2]), 8'hab);
    #1;
    check({pad_ctl[2].oe_n[0], pad_ctl[2].drv[0]}, 2'b01);
    @(posedge hclk);
    #1;
    check(pad_ctl[2].oe_n[0], 1'b1);
  endtask
  task automatic t_rmw();
    ext[3] <= 8'hc5;
    wr(ra(KPC_IDX_DATA[3]), 8'h3c);
    rdc(ra(KPC_IDX_DATA[3]), 8'hc5);
    rdc(ra(KPC_IDX_DATA[3]) + 32'h400, 8'h3c);
  endtask
  task automatic t_keys();
    ext[1] <= 8'hf5;
    wr(ra(KPC_IDX_KEY_TYPE), 8'h0c);
    wr(ra(KPC_IDX_KEY_POL), 8'h0a);
    wr(ra(KPC_IDX_KEY_EN), 8'h0f);
    rdc(FLG, 8'h00);
    ext[1] <= 8'hea;
    repeat (5) @(posedge hclk);
    rdc(FLG, 8'h0f);
    wr(FLG, 8'h03);
    rdc(FLG, 8'h03);
    ext[1] <= 8'hf5;
    repeat (5) @(posedge hclk);
    rdc(FLG, 8'h03);
    wr(FLG, 8'h00);
    wr(ra(KPC_IDX_KEY_EN), 8'h2f);
    @(posedge hclk);
    ext[1] <= 8'hd5;
    @(posedge hclk);
    ext[1] <= 8'hf5;
    repeat (5) @(posedge hclk);
    rdc(FLG, 8'h00);
    wr(FLG, 8'h80);
    rdc(FLG, 8'h80);
    check(key_irq, 1'b1);
    wr(FLG, 8'h00);
    @(negedge hclk);
    check(key_irq, 1'b0);
  endtask
  task automatic t_pd();
    @(posedge hclk);
    power_down <= 1'b1;
    @(negedge hclk);
    check(pad_ctl[1].in_en, 8'h2f);
    check(pad_ctl[0].in_en, 8'h00);
    ext[1] <= 8'hf4;
    repeat (5) @(negedge hclk);
    check(wake_req, 1'b1);
    wr(FLG, 8'h00);
    rdc(FLG, 8'h01);
    ext[1] <= 8'hf5;
    power_down <= 1'b0;
    @(negedge hclk);
    check(pad_ctl[0].in_en, 8'hff);
  endtask
  initial begin
    t_reset(1'b1);
    t_modes();
    t_rmw();
    t_keys();
    t_pd();
    t_reset(1'b0);
    conclude();
  end
endmodule
